// file: rtl/plc_consts.svh
// offsets, field positions, reset values and timing counts
`ifndef PLC_CONSTS_SVH
`define PLC_CONSTS_SVH
`define PLC_CLK_NS 10
`define PLC_MS_NS 1000000
`define PLC_REG_BMC 5'h00
`define PLC_REG_IDC 5'h18
`define PLC_REG_PHC 5'h19
`define PLC_BMC_SPEED 13
`define PLC_BMC_NEGEN 12
`define PLC_BMC_ISOLATE 10
`define PLC_BMC_RESTART 9
`define PLC_BMC_DUPLEX 8
`define PLC_BMC_RST 16'h3100
`define PLC_BMC_WMASK 16'h3500
`define PLC_PHC_AUTOX 15
`define PLC_PHC_FORCEX 14
`define PLC_PHC_LATE 7
`define PLC_PHC_CFG 5
`define PLC_PHC_RST 16'h8021
`define PLC_PHC_WMASK 16'hC07F
`define PLC_IDC_EN 4
`define PLC_IDC_VAL 1
`define PLC_IDC_RST 16'h0000
`define PLC_IDC_WMASK 16'h0012
`define PLC_BREAK_MS 1500
`define PLC_NEG_MS 3000
`define PLC_BLINK_MS 50
`define PLC_LOSS_MS 100
`define PLC_SLOT_MS 60
`define PLC_LINK_PULSES 7
`define PLC_LFSR_RST 11'h001
`endif

// file: rtl/plc_pkg.sv
// types shared by the link configuration block
package plc_pkg;
	typedef enum logic [1:0] {
		PLC_NEG_IDLE = 2'b00,
		PLC_NEG_BREAK = 2'b01,
		PLC_NEG_RUN = 2'b10,
		PLC_NEG_LINKED = 2'b11
	} plc_neg_state_t;
	typedef struct packed {
		logic valid;
		logic write;
		logic [4:0] phyAddr;
		logic [4:0] regAddr;
		logic [15:0] wdata;
	} plc_mgmt_req_t;
	typedef struct packed {
		logic ack;
		logic [15:0] rdata;
	} plc_mgmt_rsp_t;
endpackage

// file: rtl/plc_tick_gen.sv
// divider giving a one-cycle enable every PERIOD clocks
`timescale 1ns/100ps
module plc_tick_gen #(
	parameter int unsigned PERIOD = 100
) (
	input wire logic clock, // system clock
	input wire logic rstn, // async reset, active low
	output logic tick // one-cycle enable pulse
);
	localparam int unsigned W = $clog2(PERIOD);
	logic [W-1:0] count;
	logic [W-1:0] next_count;
	logic next_tick;

	// wrap the counter and flag the wrap
	always_comb begin
		next_count = count + 1'b1;
		next_tick = 1'b0;
		if (count == W'(PERIOD - 1)) begin
			next_count = '0;
			next_tick = 1'b1;
		end
	end

	// register count and pulse
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			count <= '0;
			tick <= 1'b0;
		end else begin
			count <= next_count;
			tick <= next_tick;
		end
	end
endmodule // plc_tick_gen

// file: rtl/plc_link_config.sv
// link configuration, crossover, isolate and indicator control
`timescale 1ns/100ps
`include "plc_consts.svh"
// Notes on behaviour
// - writing restart while negotiation is enabled restarts negotiation.
// - losing link after successful negotiation resumes negotiation automatically.
// - renegotiation halts data and pulses for 1500 ms, then FLP bursts.
// - negotiation should finish within about three seconds; late is flagged.
// - automatic crossover on by default, set by strap or field.
// - force-crossover bit swaps pairs regardless of negotiation or auto.
// - automatic crossover is inactive in forced speed and duplex mode.
// - a random sequence decides when auto crossover switches pairs.
// - address straps are latched into low five control bits at reset.
// - answer management only at own address; addresses must be unique.
// - strapped address zero isolates; written address zero does not.
// - unstrapped default address is one.
// - the isolate bit in basic mode control also isolates.
// - isolated: ignore transmit inputs, release all MII outputs.
// - isolated device still answers management transactions at its own address.
// - isolated line sends no packets, only idles or link pulses.
// - isolated device still negotiates and establishes receive link.
// - indicator mode from field or strap: link only, or blink.
// - 10 Mb/s link after seven pulses or a packet; loss timer drops.
// - indicator polarity follows negotiation strap sampled at reset.
// - direct-control register drives indicator; reads never show pin.
// - speed and duplex bits matter only when negotiation is disabled.
module plc_link_config #(
	parameter int unsigned MS_CYCLES = `PLC_MS_NS / `PLC_CLK_NS
) (
	input wire logic clock, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic [4:0] strapAddr, // address strap levels
	input wire logic negEnableStrap, // forced or negotiating start
	input wire logic crossoverStrap, // auto crossover strap
	input wire logic indicatorConfigIn, // indicator_config strap level
	input wire logic linkIndicatorIn, // negotiation_strap level on pin
	output logic linkIndicatorOut, // indicator pin drive value
	output logic linkIndicatorOeN, // indicator enable, low drives
	input wire plc_pkg::plc_mgmt_req_t mgmtReq, // management request
	output plc_pkg::plc_mgmt_rsp_t mgmtRsp, // management answer
	input wire logic negDone, // engine reports negotiation done
	input wire logic negSpeed100, // negotiated speed is 100
	input wire logic negFullDuplex, // negotiated full duplex
	input wire logic sigDetect, // 100 Mb/s signal detect
	input wire logic linkPulse, // normal link pulse received
	input wire logic goodPacket, // valid 10 Mb/s packet received
	input wire logic activity, // transmit or receive activity
	input wire logic txEnIn, // transmit enable from mac
	output logic lineTxEn, // packet data onto the line
	output logic lineIdleEn, // idles or link pulses onto line
	output logic flpStart, // pulse: begin FLP bursts
	output logic negRunning, // negotiation in progress
	output logic linkUp, // link good
	output logic opSpeed100, // operating speed is 100
	output logic opFullDuplex, // operating duplex is full
	output logic mdiSwap, // media pairs crossed
	output logic miiOutOeN // MII outputs enable, low drives
);
	localparam int BREAK_LAST = `PLC_BREAK_MS - 1;

	logic msTick;
	logic [15:0] basicModeControl, next_basicModeControl;
	logic [15:0] phyControl, next_phyControl;
	logic [15:0] indicatorDirectControl, next_indicatorDirectControl;
	logic strapped, next_strapped;
	logic activeLow, next_activeLow;
	plc_pkg::plc_mgmt_rsp_t next_mgmtRsp;
	plc_pkg::plc_neg_state_t negState, next_negState;
	logic [11:0] negCnt, next_negCnt;
	logic negLate, next_negLate;
	logic next_flpStart, next_opSpeed100, next_opFullDuplex;
	logic [2:0] pulseCnt, next_pulseCnt;
	logic [11:0] lossCnt, next_lossCnt;
	logic link10, next_link10, next_linkUp;
	logic [10:0] lfsr, next_lfsr;
	logic [11:0] slotCnt, next_slotCnt, slotLen, next_slotLen;
	logic xState, next_xState, next_mdiSwap;
	logic [11:0] blinkCnt, next_blinkCnt;
	logic blinkPhase, next_blinkPhase;
	logic next_linkIndicatorOut, next_linkIndicatorOeN;
	logic addrMatch, bmcWrite, restartWr, negEnRise, renegReq;
	logic negEn, isolate, autoActive, lit;

	// millisecond enable
	plc_tick_gen #(
		.PERIOD(MS_CYCLES)
	) u_msTick (
		.clock(clock),
		.rstn(rstn),
		.tick(msTick)
	);

	// decode of management writes with side effects
	// own address only
	assign addrMatch = mgmtReq.phyAddr == phyControl[4:0];
	assign bmcWrite = strapped && mgmtReq.valid && mgmtReq.write &&
		addrMatch && mgmtReq.regAddr == `PLC_REG_BMC;
	assign negEn = basicModeControl[`PLC_BMC_NEGEN];
	assign restartWr = bmcWrite && negEn &&
		mgmtReq.wdata[`PLC_BMC_RESTART];
	assign negEnRise = bmcWrite && !negEn &&
		mgmtReq.wdata[`PLC_BMC_NEGEN];
	assign renegReq = strapped && (restartWr || negEnRise ||
		(negState == plc_pkg::PLC_NEG_LINKED && !linkUp));
	assign isolate = basicModeControl[`PLC_BMC_ISOLATE];

	// register file, strap capture and management answers
	always_comb begin
		next_basicModeControl = basicModeControl;
		next_phyControl = phyControl;
		next_indicatorDirectControl = indicatorDirectControl;
		next_strapped = 1'b1;
		next_activeLow = activeLow;
		next_mgmtRsp = '0;
		if (!strapped) begin
			next_phyControl[4:0] = strapAddr;
			next_basicModeControl[`PLC_BMC_ISOLATE] = strapAddr == 5'h00;
			next_basicModeControl[`PLC_BMC_NEGEN] = negEnableStrap;
			next_phyControl[`PLC_PHC_AUTOX] = crossoverStrap;
			next_phyControl[`PLC_PHC_CFG] = indicatorConfigIn;
			next_activeLow = linkIndicatorIn;
		end else if (mgmtReq.valid && addrMatch) begin
			next_mgmtRsp.ack = 1'b1;
			if (mgmtReq.write) begin
				case (mgmtReq.regAddr)
					`PLC_REG_BMC: begin
						next_basicModeControl = (basicModeControl &
							~`PLC_BMC_WMASK) | (mgmtReq.wdata & `PLC_BMC_WMASK);
					end
					`PLC_REG_PHC: begin
						next_phyControl = (phyControl & ~`PLC_PHC_WMASK) |
							(mgmtReq.wdata & `PLC_PHC_WMASK);
					end
					`PLC_REG_IDC: begin
						next_indicatorDirectControl = (indicatorDirectControl &
							~`PLC_IDC_WMASK) | (mgmtReq.wdata & `PLC_IDC_WMASK);
					end
					default: begin
					end
				endcase
			end else begin
				case (mgmtReq.regAddr)
					`PLC_REG_BMC: next_mgmtRsp.rdata = basicModeControl;
					`PLC_REG_PHC: begin
						next_mgmtRsp.rdata = phyControl;
						next_mgmtRsp.rdata[`PLC_PHC_LATE] = negLate;
					end
					`PLC_REG_IDC: next_mgmtRsp.rdata = indicatorDirectControl;
					default: next_mgmtRsp.rdata = 16'h0000;
				endcase
			end
		end
	end

	// registers; default address one
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			basicModeControl <= `PLC_BMC_RST;
			phyControl <= `PLC_PHC_RST;
			indicatorDirectControl <= `PLC_IDC_RST;
			strapped <= 1'b0;
			activeLow <= 1'b0;
			mgmtRsp <= '0;
		end else begin
			basicModeControl <= next_basicModeControl;
			phyControl <= next_phyControl;
			indicatorDirectControl <= next_indicatorDirectControl;
			strapped <= next_strapped;
			activeLow <= next_activeLow;
			mgmtRsp <= next_mgmtRsp;
		end
	end

	// negotiation sequencing, break timer and late watchdog
	// isolate plays no part here
	always_comb begin
		next_negState = negState;
		next_negCnt = negCnt;
		next_negLate = negLate;
		next_flpStart = 1'b0;
		next_opSpeed100 = negEn ? negSpeed100 :
			basicModeControl[`PLC_BMC_SPEED];
		next_opFullDuplex = negEn ? negFullDuplex :
			basicModeControl[`PLC_BMC_DUPLEX];
		if (renegReq) begin
			next_negState = plc_pkg::PLC_NEG_BREAK;
			next_negCnt = 12'h000;
			next_negLate = 1'b0;
		end else if (!negEn || !strapped) begin
			next_negState = plc_pkg::PLC_NEG_IDLE;
		end else begin
			case (negState)
				plc_pkg::PLC_NEG_IDLE: begin
					next_negState = plc_pkg::PLC_NEG_RUN;
					next_negCnt = 12'h000;
					next_flpStart = 1'b1;
				end
				// hold off until break timer ends
				plc_pkg::PLC_NEG_BREAK: begin
					if (msTick && negCnt == 12'(BREAK_LAST)) begin
						next_negState = plc_pkg::PLC_NEG_RUN;
						next_negCnt = 12'h000;
						next_flpStart = 1'b1;
					end else if (msTick) begin
						next_negCnt = negCnt + 12'h001;
					end
				end
				plc_pkg::PLC_NEG_RUN: begin
					if (negDone) begin
						next_negState = plc_pkg::PLC_NEG_LINKED;
					end else if (msTick && !negLate) begin
						if (negCnt == 12'(`PLC_NEG_MS - 1)) begin
							next_negLate = 1'b1;
						end else begin
							next_negCnt = negCnt + 12'h001;
						end
					end
				end
				plc_pkg::PLC_NEG_LINKED: begin
				end
				default: next_negState = plc_pkg::PLC_NEG_IDLE;
			endcase
		end
	end

	// negotiation registers
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			negState <= plc_pkg::PLC_NEG_IDLE;
			negCnt <= 12'h000;
			negLate <= 1'b0;
			flpStart <= 1'b0;
			opSpeed100 <= 1'b0;
			opFullDuplex <= 1'b0;
		end else begin
			negState <= next_negState;
			negCnt <= next_negCnt;
			negLate <= next_negLate;
			flpStart <= next_flpStart;
			opSpeed100 <= next_opSpeed100;
			opFullDuplex <= next_opFullDuplex;
		end
	end

	// 10 Mb/s link qualification and loss timer
	always_comb begin
		next_pulseCnt = pulseCnt;
		next_lossCnt = lossCnt;
		next_link10 = link10;
		if (linkPulse || goodPacket) begin
			next_lossCnt = 12'h000;
		end else if (msTick) begin
			if (lossCnt == 12'(`PLC_LOSS_MS - 1)) begin
				next_lossCnt = 12'h000;
				next_link10 = 1'b0;
				next_pulseCnt = 3'h0;
			end else begin
				next_lossCnt = lossCnt + 12'h001;
			end
		end
		if (goodPacket) begin
			next_link10 = 1'b1;
		end
		if (linkPulse) begin
			if (pulseCnt == 3'(`PLC_LINK_PULSES - 1)) begin
				next_link10 = 1'b1;
			end else begin
				next_pulseCnt = pulseCnt + 3'h1;
			end
		end
		next_linkUp = opSpeed100 ? sigDetect : next_link10;
	end

	// link registers
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pulseCnt <= 3'h0;
			lossCnt <= 12'h000;
			link10 <= 1'b0;
			linkUp <= 1'b0;
		end else begin
			pulseCnt <= next_pulseCnt;
			lossCnt <= next_lossCnt;
			link10 <= next_link10;
			linkUp <= next_linkUp;
		end
	end

	assign autoActive = phyControl[`PLC_PHC_AUTOX] && negEn;

	// crossover slots of random length
	always_comb begin
		next_lfsr = {lfsr[9:0], lfsr[10] ^ lfsr[8]};
		next_slotCnt = slotCnt;
		next_slotLen = slotLen;
		next_xState = xState;
		if (msTick) begin
			if (slotCnt >= slotLen) begin
				next_slotCnt = 12'h000;
				next_slotLen = 12'(`PLC_SLOT_MS) + {8'h00, lfsr[3:0]};
				if (!linkUp && autoActive) begin
					next_xState = !xState;
				end
			end else begin
				next_slotCnt = slotCnt + 12'h001;
			end
		end
		next_mdiSwap = phyControl[`PLC_PHC_FORCEX] || (autoActive && xState);
	end

	// crossover registers
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			lfsr <= `PLC_LFSR_RST;
			slotCnt <= 12'h000;
			slotLen <= 12'(`PLC_SLOT_MS);
			xState <= 1'b0;
			mdiSwap <= 1'b0;
		end else begin
			lfsr <= next_lfsr;
			slotCnt <= next_slotCnt;
			slotLen <= next_slotLen;
			xState <= next_xState;
			mdiSwap <= next_mdiSwap;
		end
	end

	// blink timer and indicator drive
	always_comb begin
		next_blinkCnt = blinkCnt;
		next_blinkPhase = blinkPhase;
		if (msTick) begin
			if (blinkCnt == 12'(`PLC_BLINK_MS - 1)) begin
				next_blinkCnt = 12'h000;
				next_blinkPhase = !blinkPhase;
			end else begin
				next_blinkCnt = blinkCnt + 12'h001;
			end
		end
		lit = linkUp && (phyControl[`PLC_PHC_CFG] || !activity ||
			blinkPhase);
		if (indicatorDirectControl[`PLC_IDC_EN]) begin
			lit = indicatorDirectControl[`PLC_IDC_VAL];
		end
		next_linkIndicatorOut = lit ^ activeLow;
		next_linkIndicatorOeN = !strapped;
	end

	// indicator registers
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			blinkCnt <= 12'h000;
			blinkPhase <= 1'b0;
			linkIndicatorOut <= 1'b0;
			linkIndicatorOeN <= 1'b1;
		end else begin
			blinkCnt <= next_blinkCnt;
			blinkPhase <= next_blinkPhase;
			linkIndicatorOut <= next_linkIndicatorOut;
			linkIndicatorOeN <= next_linkIndicatorOeN;
		end
	end

	// release MII, ignore transmit; idles only
	assign miiOutOeN = isolate;
	assign lineTxEn = txEnIn && !isolate &&
		negState != plc_pkg::PLC_NEG_BREAK;
	assign lineIdleEn = negState != plc_pkg::PLC_NEG_BREAK;
	assign negRunning = negState == plc_pkg::PLC_NEG_RUN;

	// checks on the sequencing and outputs
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	AST_RESTART_BREAK: assert property (
		restartWr |=> negState == plc_pkg::PLC_NEG_BREAK)
		else $error("restart write did not enter break");
	AST_LOSS_RENEG: assert property (
		negState == plc_pkg::PLC_NEG_LINKED && !linkUp && strapped
		|=> negState == plc_pkg::PLC_NEG_BREAK)
		else $error("link loss did not renegotiate");
	AST_BREAK_SILENT: assert property (
		negState == plc_pkg::PLC_NEG_BREAK |-> !lineIdleEn && !lineTxEn)
		else $error("line active during break");
	AST_BREAK_FULL: assert property (
		$past(negState) == plc_pkg::PLC_NEG_BREAK &&
		negState == plc_pkg::PLC_NEG_RUN
		|-> $past(negCnt) == 12'(BREAK_LAST) && flpStart)
		else $error("break ended early");
	AST_FORCE_SWAP: assert property (
		phyControl[`PLC_PHC_FORCEX] |=> mdiSwap)
		else $error("force crossover ignored");
	AST_NO_AUTO_FORCED: assert property (
		!negEn && !phyControl[`PLC_PHC_FORCEX] |=> !mdiSwap)
		else $error("auto crossover in forced mode");
	AST_STRAP_ADDR: assert property (
		$rose(strapped) |-> phyControl[4:0] == $past(strapAddr) &&
		isolate == ($past(strapAddr) == 5'h00))
		else $error("address strap not latched");
	AST_FOREIGN_SILENT: assert property (
		mgmtReq.valid && !addrMatch |=> !mgmtRsp.ack)
		else $error("answered foreign address");
	AST_ISOLATE_MII: assert property (
		isolate |-> miiOutOeN && !lineTxEn)
		else $error("isolated but driving");
	AST_DIRECT_DRIVE: assert property (
		indicatorDirectControl[`PLC_IDC_EN] |=> linkIndicatorOut ==
		($past(indicatorDirectControl[`PLC_IDC_VAL]) ^ $past(activeLow)))
		else $error("direct indicator value not driven");
	COV_RESTART: cover property (restartWr ##1
		negState == plc_pkg::PLC_NEG_BREAK);
	COV_LINKED: cover property (negState == plc_pkg::PLC_NEG_RUN ##1
		negState == plc_pkg::PLC_NEG_LINKED);
	COV_ISOLATED_ACK: cover property (isolate && mgmtRsp.ack);
	COV_BLINK: cover property (linkUp && activity && $changed(blinkPhase));
endmodule // plc_link_config

// file: testbench/plc_link_partner.sv
// far side model: negotiation engine and remote link partner
`timescale 1ns/100ps
module plc_link_partner #(
	parameter int unsigned NEG_CYCLES = 20 // cycles to finish negotiating
) (
	input wire logic clock, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic flpStart, // device begins FLP bursts
	input wire logic lineIdleEn, // device sends idles or pulses
	input wire logic cableOn, // cable attached
	input wire logic sendPulses, // send normal link pulses
	output logic negDone, // negotiation complete
	output logic negSpeed100, // result speed 100
	output logic negFullDuplex, // result full duplex
	output logic sigDetect, // 100 Mb/s signal detect
	output logic linkPulse, // one normal link pulse
	output logic goodPacket // valid packet, never sent
);
	logic busy, next_busy, next_negDone, next_linkPulse;
	logic [7:0] negCnt, next_negCnt;
	logic [3:0] pulseCnt, next_pulseCnt;
	// fixed negotiated result, signal only while linked
	assign negSpeed100 = 1'h1;
	assign negFullDuplex = 1'h1;
	assign goodPacket = 1'h0;
	assign sigDetect = negDone;
	// next state of negotiation and pulse train
	always_comb begin
		next_busy = busy;
		next_negDone = negDone;
		next_negCnt = negCnt + 8'h01;
		next_pulseCnt = sendPulses ? pulseCnt + 4'h1 : 4'h0;
		next_linkPulse = sendPulses && pulseCnt == 4'hF;
		if (!lineIdleEn || !cableOn) begin
			next_busy = 1'h0;
			next_negDone = 1'h0;
		end else if (flpStart) begin
			next_busy = 1'h1;
			next_negCnt = 8'h00;
		end else if (busy && negCnt == NEG_CYCLES[7:0]) begin
			next_busy = 1'h0;
			next_negDone = 1'h1;
		end
	end
	// registers of the far side
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			busy <= 1'h0;
			negDone <= 1'h0;
			negCnt <= 8'h00;
			pulseCnt <= 4'h0;
			linkPulse <= 1'h0;
		end else begin
			busy <= next_busy;
			negDone <= next_negDone;
			negCnt <= next_negCnt;
			pulseCnt <= next_pulseCnt;
			linkPulse <= next_linkPulse;
		end
	end
endmodule // plc_link_partner

// file: testbench/plc_link_config_tb.sv
// self-checking bench for the link configuration block
`timescale 1ns/100ps
module plc_link_config_tb;
	typedef struct packed {
		logic wr;
		logic [4:0] ra;
		logic [15:0] wd;
		logic [15:0] ex;
	} plc_row_t;
	logic clock = 1'h0;
	logic rstn = 1'h0;
	logic [4:0] strapAddr = 5'h01;
	logic negStrap = 1'h1;
	logic xStrap = 1'h1;
	logic cfgStrap = 1'h1;
	logic ledStrap = 1'h0;
	logic activity = 1'h0;
	logic txEnIn = 1'h0;
	logic cableOn = 1'h1;
	logic sendPulses = 1'h0;
	logic [4:0] curAddr = 5'h01;
	plc_pkg::plc_mgmt_req_t mgmtReq = '0;
	plc_pkg::plc_mgmt_rsp_t mgmtRsp;
	logic ledOut, ledOeN, ledWire, flpStart, negRunning, linkUp, prev;
	logic negDone, negSpeed100, negFullDuplex, sigDetect, linkPulse;
	logic goodPacket, lineTxEn, lineIdleEn, opSpeed100, opFullDuplex;
	logic mdiSwap, miiOutOeN, ok;
	logic [15:0] rd;
	int errCount = 0;
	int checked = 0;
	int n;
	plc_row_t rows [9] = '{
		'{1'h0, 5'h19, 16'h0000, 16'h8021},
		'{1'h0, 5'h00, 16'h0000, 16'h3100},
		'{1'h0, 5'h18, 16'h0000, 16'h0000},
		'{1'h0, 5'h05, 16'h0000, 16'h0000},
		'{1'h1, 5'h18, 16'hFFFF, 16'h0000},
		'{1'h0, 5'h18, 16'h0000, 16'h0012},
		'{1'h1, 5'h18, 16'h0000, 16'h0000},
		'{1'h1, 5'h00, 16'h1100, 16'h0000},
		'{1'h0, 5'h00, 16'h0000, 16'h1100}
	};
	// indicator pin: strap resistor unless the device drives
	assign ledWire = ledOeN ? ledStrap : ledOut;
	// free-running 100 MHz clock
	initial begin
		forever #5 clock = ~clock;
	end
	plc_link_config #(.MS_CYCLES(4)) u_plc_link_config (
		.clock(clock), .rstn(rstn), .strapAddr(strapAddr),
		.negEnableStrap(negStrap), .crossoverStrap(xStrap),
		.indicatorConfigIn(cfgStrap), .linkIndicatorIn(ledWire),
		.linkIndicatorOut(ledOut), .linkIndicatorOeN(ledOeN),
		.mgmtReq(mgmtReq), .mgmtRsp(mgmtRsp), .negDone(negDone),
		.negSpeed100(negSpeed100), .negFullDuplex(negFullDuplex),
		.sigDetect(sigDetect), .linkPulse(linkPulse),
		.goodPacket(goodPacket), .activity(activity), .txEnIn(txEnIn),
		.lineTxEn(lineTxEn), .lineIdleEn(lineIdleEn), .flpStart(flpStart),
		.negRunning(negRunning), .linkUp(linkUp), .opSpeed100(opSpeed100),
		.opFullDuplex(opFullDuplex), .mdiSwap(mdiSwap),
		.miiOutOeN(miiOutOeN)
	);
	plc_link_partner u_plc_link_partner (
		.clock(clock), .rstn(rstn), .flpStart(flpStart),
		.lineIdleEn(lineIdleEn), .cableOn(cableOn),
		.sendPulses(sendPulses), .negDone(negDone),
		.negSpeed100(negSpeed100), .negFullDuplex(negFullDuplex),
		.sigDetect(sigDetect), .linkPulse(linkPulse),
		.goodPacket(goodPacket)
	);
	// compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			errCount++;
			$display("[FAIL] time %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// wait n clocks, settle past the edge
	task automatic cyc(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask
	// one management access, ack awaited for three cycles
	task automatic mgmt(input logic wr, input logic [4:0] ra,
			input logic [15:0] wd);
		ok = 1'h0;
		rd = 16'h0000;
		@(posedge clock);
		mgmtReq <= '{1'h1, wr, curAddr, ra, wd};
		@(posedge clock);
		mgmtReq <= '0;
		repeat (3) begin
			#1;
			if (mgmtRsp.ack === 1'h1 && !ok) begin
				ok = 1'h1;
				rd = mgmtRsp.rdata;
			end
			@(posedge clock);
		end
		#1;
	endtask
	// bounded wait on link (0) or burst start (1)
	task automatic waitOn(input int sel, input int lim, output int cnt);
		logic hit;
		cnt = 0;
		hit = 1'h0;
		while (!hit && cnt < lim) begin
			@(posedge clock);
			#1;
			cnt++;
			hit = sel == 0 ? linkUp === 1'h1 : flpStart === 1'h1;
		end
	endtask
	// counts and verdict
	task automatic giveVerdict;
		$display("checks %0d mismatches %0d", checked, errCount);
		if (errCount == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// watchdog against a hang
	initial begin
		repeat (40000) @(posedge clock);
		errCount++;
		giveVerdict;
	end
	// main sequence
	initial begin
		cyc(2);
		check({flpStart, mgmtRsp.ack, ledOeN, lineIdleEn, miiOutOeN}, 16'h0006);
		@(posedge clock);
		@(posedge clock);
		rstn <= 1'h1;
		waitOn(0, 200, n);
		check({linkUp, opSpeed100, opFullDuplex}, 16'h0007);
		for (int i = 0; i < 9; i++) begin
			mgmt(rows[i].wr, rows[i].ra, rows[i].wd);
			check(ok, 1'h1);
			if (!rows[i].wr) check(rd, rows[i].ex);
		end
		check({opSpeed100, ledOut, ledOeN}, 16'h0006);
		curAddr = 5'h02;
		mgmt(1'h0, 5'h00, 16'h0000);
		check(ok, 1'h0);
		curAddr = 5'h01;
		mgmt(1'h1, 5'h18, 16'h0010);
		cyc(3);
		check(ledOut, 1'h0);
		mgmt(1'h1, 5'h18, 16'h0000);
		cyc(3);
		check(ledOut, 1'h1);
		mgmt(1'h1, 5'h19, 16'h8001);
		@(posedge clock);
		activity <= 1'h1;
		n = 0;
		prev = ledOut;
		for (int i = 0; i < 450; i++) begin
			cyc(1);
			if (ledOut !== prev) n++;
			prev = ledOut;
		end
		check(n >= 2, 1'h1);
		@(posedge clock);
		activity <= 1'h0;
		txEnIn <= 1'h1;
		mgmt(1'h1, 5'h19, 16'h8021);
		check(lineTxEn, 1'h1);
		mgmt(1'h1, 5'h00, 16'h3300);
		check({lineIdleEn, lineTxEn}, 16'h0000);
		waitOn(1, 6200, n);
		check(n >= 5980 && n <= 6010, 1'h1);
		check(negRunning, 1'h1);
		waitOn(0, 200, n);
		check(linkUp, 1'h1);
		mgmt(1'h1, 5'h00, 16'h3500);
		check({miiOutOeN, lineTxEn, lineIdleEn}, 16'h0005);
		mgmt(1'h0, 5'h00, 16'h0000);
		check(ok, 1'h1);
		check(rd, 16'h3500);
		check(linkUp, 1'h1);
		mgmt(1'h1, 5'h00, 16'h3100);
		check(miiOutOeN, 1'h0);
		@(posedge clock);
		cableOn <= 1'h0;
		cyc(4);
		check({linkUp, lineIdleEn}, 16'h0000);
		waitOn(1, 6200, n);
		cyc(12050);
		mgmt(1'h0, 5'h19, 16'h0000);
		check(rd, 16'h80A1);
		mgmt(1'h1, 5'h00, 16'h0000);
		cyc(3);
		check({opSpeed100, mdiSwap}, 16'h0000);
		mgmt(1'h1, 5'h19, 16'h4021);
		cyc(3);
		check(mdiSwap, 1'h1);
		@(posedge clock);
		sendPulses <= 1'h1;
		cyc(104);
		check(linkUp, 1'h0);
		cyc(16);
		check(linkUp, 1'h1);
		@(posedge clock);
		sendPulses <= 1'h0;
		cyc(500);
		check(linkUp, 1'h0);
		@(posedge clock);
		rstn <= 1'h0;
		strapAddr <= 5'h00;
		negStrap <= 1'h0;
		xStrap <= 1'h0;
		ledStrap <= 1'h1;
		cyc(4);
		@(posedge clock);
		rstn <= 1'h1;
		cyc(3);
		curAddr = 5'h00;
		check({miiOutOeN, ledOut}, 16'h0003);
		mgmt(1'h0, 5'h00, 16'h0000);
		check(rd, 16'h2500);
		mgmt(1'h0, 5'h19, 16'h0000);
		check(rd, 16'h0020);
		mgmt(1'h1, 5'h00, 16'h2700);
		check(lineIdleEn, 1'h1);
		mgmt(1'h1, 5'h00, 16'h3500);
		check(lineIdleEn, 1'h0);
		giveVerdict;
	end
endmodule // plc_link_config_tb
